// ===== dsw_checker.sv
// port assertions for the serial write port
// assumes the bind below and a 14-bit code word
`timescale 1ns/100ps
`default_nettype none
`include "dsw_regs.vh"
module dsw_checker #(
    parameter DATA_BITS = 14,
    parameter RESET_MIDSCALE = 1
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic sync_n,
    input wire logic [DATA_BITS-1:0] analog_output,
    input wire logic [1:0] power_mode,
    input wire logic output_active,
    input wire logic load_hiz,
    input wire logic load_100k,
    input wire logic load_1k,
    input wire logic update_pulse,
    input wire logic abort_pulse
);
    // reset code follows the variant: midscale is the top bit alone
    localparam [DATA_BITS-1:0] CODE_RESET = RESET_MIDSCALE ?
        {1'h1, {(DATA_BITS-1){1'h0}}} : {DATA_BITS{1'h0}};
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    // pulses are single cycles and never coincide
    a_update_single: assert property (update_pulse |=> !update_pulse) else $error("update too long");
    a_abort_single: assert property (abort_pulse |=> !abort_pulse) else $error("abort too long");
    a_no_both: assert property (!(update_pulse && abort_pulse)) else $error("update with abort");
    // the code only moves with an update, so an abort leaves it alone
    a_idle_stable: assert property (!update_pulse |-> $stable(analog_output) && $stable(power_mode))
        else $error("output moved");
    a_update_frame: assert property (update_pulse |-> !$past(sync_n, 6)) else $error("update outside frame");
    // loads trail the mode by one cycle
    a_loads_onehot: assert property ($onehot({output_active, load_hiz, load_100k, load_1k}))
        else $error("loads not one-hot");
    a_active_mode: assert property (output_active == ($past(power_mode) == `DSW_MODE_NORMAL))
        else $error("active wrong");
    a_hiz_mode: assert property (load_hiz == ($past(power_mode) == `DSW_MODE_PD_HIZ)) else $error("hiz wrong");
    // reset value is checked while reset is held, so no disable here
    a_reset_value: assert property (disable iff (1'h0) !resetn |=> analog_output == CODE_RESET
        && power_mode == `DSW_MODE_NORMAL) else $error("reset code wrong");
endmodule // dsw_checker
bind dsw_write_port dsw_checker #(.DATA_BITS(DATA_BITS), .RESET_MIDSCALE(RESET_MIDSCALE)) chk_i (
    .core_clk(core_clk), .resetn(resetn),
    .sync_n(sync_n), .analog_output(analog_output), .power_mode(power_mode), .output_active(output_active),
    .load_hiz(load_hiz), .load_100k(load_100k), .load_1k(load_1k), .update_pulse(update_pulse),
    .abort_pulse(abort_pulse));
`default_nettype wire

// ===== dsw_host_model.sv
// host end of the three-wire write link
// assumes the caller waits for send to return before the next frame
`timescale 1ns/100ps
`default_nettype none
module dsw_host_model (
    input wire logic core_clk,
    output logic sync_n,
    output logic sclk,
    output logic din
);
    initial begin
        sync_n = 1'h1;
        sclk = 1'h0;
        din = 1'h0;
    end
    // msb first; data moves on the rise so it is steady around each fall
    // every change is a non-blocking update on a core_clk rise; 8 cycles make one 400 ns link period
    task send(input logic [23:0] word, input int n);
        int i;
        @(posedge core_clk);
        sync_n <= 1'h0;
        for (i = n - 1; i >= 0; i--) begin
            repeat (4) @(posedge core_clk);
            sclk <= 1'h1;
            din <= word[i];
            repeat (4) @(posedge core_clk);
            sclk <= 1'h0;
        end
        repeat (4) @(posedge core_clk);
        sync_n <= 1'h1;
        din <= ~din; // released line must not keep a stale level
        repeat (8) @(posedge core_clk);
    endtask
endmodule // dsw_host_model
`default_nettype wire

// ===== dsw_regs.vh
// constants for the serial write port of a single-channel converter
// assumes the includer uses the names below for mode and width figures
`ifndef DSW_REGS_VH
`define DSW_REGS_VH

// ****************************************************************
// command word layout and bit counter
// ****************************************************************
`define DSW_MODE_BITS 2
`define DSW_CNT_BITS 5
`define DSW_CNT_ZERO 5'h00
`define DSW_CNT_ONE 5'h01

// ****************************************************************
// output modes carried in the mode field
// ****************************************************************
`define DSW_MODE_NORMAL 2'h0
`define DSW_MODE_PD_1K 2'h1
`define DSW_MODE_PD_100K 2'h2
`define DSW_MODE_PD_HIZ 2'h3

// ****************************************************************
// synchroniser rest levels
// ****************************************************************
`define DSW_IDLE_HIGH 1'h1
`define DSW_IDLE_LOW 1'h0

`endif

// ===== dsw_sync.v
// two-stage synchroniser for one pin coming from outside core_clk
// assumes a synchronous active-low reset on the same clock
`timescale 1ns/100ps
`default_nettype none

module dsw_sync #(
    parameter [0:0] RST_VAL = 1'h0
) (
    input wire core_clk,
    input wire resetn,
    input wire pin_in,
    output wire pin_sync
);

    reg meta_q;
    reg sync_q;

    // the first stage feeds only the second stage
    always @(posedge core_clk) begin
        if (!resetn) begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
        end else begin
            meta_q <= pin_in;
            sync_q <= meta_q;
        end
    end

    assign pin_sync = sync_q;

endmodule // dsw_sync

`default_nettype wire

// ===== dsw_write_port.v
// serial write port of a single-channel voltage-output converter
// assumes frame sync, shift clock and data arrive from a host on pins,
// asynchronous to core_clk; the shift clock is oversampled by core_clk
//
// Summary of operation
// RQ1 - frame sync low opens the frame and enables the input shift register.
// RQ2 - data is sampled on each falling shift-clock edge while the frame is open; here only until the word completes.
// RQ3 - output updates from the shifted word once the full word count is reached.
// RQ4 - frame sync rising before the word completes aborts; partial word discarded; here a frame with no bits gives no abort.
// RQ5 - shift clock up to 30 MHz; host keeps below it, device must keep up; here core_clk oversampling caps it well below.
// RQ6 - sixteen-bit command for the 14-bit variant, 24-bit for 16-bit variants.
// RQ7 - normal mode plus three power-down loads: high impedance, 100k, 1k to ground.
// RQ8 - after reset the code is midscale or zero until the first complete write.
// RQ9 - words arrive most significant bit first, mode bits ahead of the code.
`timescale 1ns/100ps
`default_nettype none
`include "dsw_regs.vh"

module dsw_write_port #(
    parameter DATA_BITS = 14,
    parameter WORD_BITS = 16,
    parameter RESET_MIDSCALE = 1
) (
    input wire core_clk,
    input wire resetn,
    input wire sync_n,
    input wire sclk,
    input wire din,
    output wire [DATA_BITS-1:0] analog_output,
    output wire [1:0] power_mode,
    output wire output_active,
    output wire load_hiz,
    output wire load_100k,
    output wire load_1k,
    output wire update_pulse,
    output wire abort_pulse
);

    // ****************************************************************
    // derived constants
    // ****************************************************************
    localparam MODE_LSB = DATA_BITS;
    localparam MODE_MSB = DATA_BITS + `DSW_MODE_BITS - 1;
    // word length cut to the counter width on purpose; 24 still fits
    localparam [31:0] WORD_BITS_W = WORD_BITS;
    localparam [`DSW_CNT_BITS-1:0] WORD_LEN = WORD_BITS_W[`DSW_CNT_BITS-1:0];
    // midscale is the top bit alone; zero scale is all clear
    localparam [DATA_BITS-1:0] CODE_RESET = RESET_MIDSCALE ?
        {1'h1, {(DATA_BITS-1){1'h0}}} : {DATA_BITS{1'h0}};

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    wire sync_n_s;
    wire sclk_s;
    wire din_s;

    // all three pins share the same two-cycle delay, so their
    // relative timing as seen by core_clk is preserved
    dsw_sync #(.RST_VAL(`DSW_IDLE_HIGH)) u_sync_fs (
        .core_clk(core_clk),
        .resetn(resetn),
        .pin_in(sync_n),
        .pin_sync(sync_n_s)
    );

    dsw_sync #(.RST_VAL(`DSW_IDLE_LOW)) u_sync_ck (
        .core_clk(core_clk),
        .resetn(resetn),
        .pin_in(sclk),
        .pin_sync(sclk_s)
    );

    dsw_sync #(.RST_VAL(`DSW_IDLE_LOW)) u_sync_di (
        .core_clk(core_clk),
        .resetn(resetn),
        .pin_in(din),
        .pin_sync(din_s)
    );

    // ****************************************************************
    // edge detection
    // ****************************************************************
    reg sclk_prev_q;
    reg sync_prev_q;

    // history of the synchronised levels, never of the first stage
    always @(posedge core_clk) begin
        if (!resetn) begin
            sclk_prev_q <= `DSW_IDLE_LOW;
            sync_prev_q <= `DSW_IDLE_HIGH;
        end else begin
            sclk_prev_q <= sclk_s;
            sync_prev_q <= sync_n_s;
        end
    end

    wire frame_open = ~sync_n_s; // RQ1
    wire sclk_fall = sclk_prev_q & ~sclk_s; // RQ5
    wire sync_rise = ~sync_prev_q & sync_n_s;

    // ****************************************************************
    // input shift register and bit counter
    // ****************************************************************
    reg [WORD_BITS-1:0] shift_q;
    reg [WORD_BITS-1:0] shift_d;
    reg [`DSW_CNT_BITS-1:0] count_q;
    reg [`DSW_CNT_BITS-1:0] count_d;
    reg done_q;
    reg done_d;
    reg load_now;

    // extra edges after a complete word are ignored until the frame
    // closes, so a long burst cannot smear the latched command
    always @* begin
        shift_d = shift_q;
        count_d = count_q;
        done_d = done_q;
        load_now = 1'h0;
        if (!frame_open) begin
            count_d = `DSW_CNT_ZERO; // RQ4
            done_d = 1'h0;
        end else if (sclk_fall && !done_q) begin
            shift_d = {shift_q[WORD_BITS-2:0], din_s}; // RQ2 RQ9
            count_d = count_q + `DSW_CNT_ONE;
            if (count_d == WORD_LEN) begin
                done_d = 1'h1;
                load_now = 1'h1; // RQ3 RQ6
            end
        end
    end

    always @(posedge core_clk) begin
        if (!resetn) begin
            shift_q <= {WORD_BITS{1'h0}};
            count_q <= `DSW_CNT_ZERO;
            done_q <= 1'h0;
        end else begin
            shift_q <= shift_d;
            count_q <= count_d;
            done_q <= done_d;
        end
    end

    // ****************************************************************
    // output latch
    // ****************************************************************
    reg [DATA_BITS-1:0] code_q;
    reg [1:0] mode_q;
    reg update_q;
    reg abort_q;

    // the latch only moves on a completed word; an aborted frame
    // never reaches here, so the output stays put
    always @(posedge core_clk) begin
        if (!resetn) begin
            code_q <= CODE_RESET; // RQ8
            mode_q <= `DSW_MODE_NORMAL;
            update_q <= 1'h0;
            abort_q <= 1'h0;
        end else begin
            update_q <= load_now;
            abort_q <= sync_rise & ~done_q & (count_q != `DSW_CNT_ZERO); // RQ4
            if (load_now) begin
                code_q <= shift_d[DATA_BITS-1:0]; // RQ3
                mode_q <= shift_d[MODE_MSB:MODE_LSB]; // RQ7 RQ9
            end
        end
    end

    // ****************************************************************
    // mode decode
    // ****************************************************************
    reg act_d;
    reg hiz_d;
    reg r100k_d;
    reg r1k_d;

    // exactly one of active and the three loads is selected at any time
    always @* begin
        act_d = 1'h0;
        hiz_d = 1'h0;
        r100k_d = 1'h0;
        r1k_d = 1'h0;
        case (mode_q)
            `DSW_MODE_NORMAL: begin
                act_d = 1'h1;
            end
            `DSW_MODE_PD_1K: begin
                r1k_d = 1'h1; // RQ7
            end
            `DSW_MODE_PD_100K: begin
                r100k_d = 1'h1; // RQ7
            end
            default: begin
                hiz_d = 1'h1; // RQ7
            end
        endcase
    end

    reg act_q;
    reg hiz_q;
    reg r100k_q;
    reg r1k_q;

    // registered so the load switches never see decode glitches
    always @(posedge core_clk) begin
        if (!resetn) begin
            act_q <= 1'h1;
            hiz_q <= 1'h0;
            r100k_q <= 1'h0;
            r1k_q <= 1'h0;
        end else begin
            act_q <= act_d;
            hiz_q <= hiz_d;
            r100k_q <= r100k_d;
            r1k_q <= r1k_d;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    // limitation: oversampling at core_clk caps the usable shift clock
    // well below the pin rating; a faster host needs a faster core_clk
    assign analog_output = code_q;
    assign power_mode = mode_q;
    assign output_active = act_q;
    assign load_hiz = hiz_q;
    assign load_100k = r100k_q;
    assign load_1k = r1k_q;
    assign update_pulse = update_q;
    assign abort_pulse = abort_q;

endmodule // dsw_write_port

`default_nettype wire

// ===== dsw_write_port_test.sv
// self-checking bench for the serial write port
// assumes the host model drives the link with its own phase
`timescale 1ns/100ps
`default_nettype none
module dsw_write_port_test;
    logic core_clk = 1'h0;
    logic resetn = 1'h0;
    wire sync_n, sclk, din, output_active, load_hiz, load_100k, load_1k, update_pulse, abort_pulse;
    wire [13:0] analog_output;
    wire [1:0] power_mode;
    int n_errors = 0, compares = 0, seed = 99, n_upd = 0, n_abt = 0, e_upd = 0, e_abt = 0, i;
    int e_code = 'h2000, e_mode = 0;
    initial forever #25 core_clk = ~core_clk;
    dsw_host_model host (.core_clk(core_clk), .sync_n(sync_n), .sclk(sclk), .din(din));
    dsw_write_port dut (.core_clk(core_clk), .resetn(resetn), .sync_n(sync_n), .sclk(sclk), .din(din),
        .analog_output(analog_output), .power_mode(power_mode), .output_active(output_active),
        .load_hiz(load_hiz), .load_100k(load_100k), .load_1k(load_1k), .update_pulse(update_pulse),
        .abort_pulse(abort_pulse));
    // pulse counts, compared with the model after each frame
    always @(posedge core_clk) begin
        if (update_pulse === 1'h1) n_upd <= n_upd + 1;
        if (abort_pulse === 1'h1) n_abt <= n_abt + 1;
    end
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // model: the first sixteen bits make the word, fewer bits keep code and mode and, if any came, count an abort
    task frame(input logic [23:0] w, input int n);
        host.send(w, n);
        @(negedge core_clk);
        if (n >= 16) begin
            e_mode = (w >> (n - 2)) & 3;
            e_code = (w >> (n - 16)) & 'h3fff;
            e_upd++;
        end else if (n > 0) e_abt++;
        chk(analog_output, e_code);
        chk(power_mode, e_mode);
        chk({output_active, load_1k, load_100k, load_hiz}, {e_mode == 0, e_mode == 1, e_mode == 2, e_mode == 3});
        chk(n_upd, e_upd);
        chk(n_abt, e_abt);
    endtask
    task complete_run;
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        #500000;
        n_errors++;
        complete_run;
    end
    initial begin
        repeat (12) @(posedge core_clk);
        resetn <= 1'h1;
        @(posedge core_clk);
        frame(24'h0, 0);
        for (i = 0; i < 4; i++) frame({i[1:0], 14'($random(seed))}, 16);
        frame(24'($random(seed)), 5);
        frame(24'($random(seed)), 15);
        frame(24'($random(seed)), 18);
        repeat (4) frame(24'($random(seed)), 16);
        // a second reset mid-run must bring back midscale
        @(posedge core_clk) resetn <= 1'h0;
        repeat (3) @(posedge core_clk);
        resetn <= 1'h1;
        @(negedge core_clk);
        chk(analog_output, 'h2000);
        chk({power_mode, output_active}, 3'h1);
        complete_run;
    end
endmodule // dsw_write_port_test
`default_nettype wire
